// [rtl/vrad_decoder.sv]
// vrad_decoder: system address decoder with low vector overlay and bus-cycle abort flags
// assumes one request per cycle from the core bus, answered one cycle later;
// the mapping-mode write strobe comes from system control logic on the same clock
// the flash, sram and slot parameters must match the memories and peripherals fitted;
// request inputs are not synchronised, so the core must run on sys_clk as well
//
// Functional notes
// - eight vector words sit at word addresses 0x00 through 0x1C.
// - any reset selects boot-loader mapping, boot block vectors overlay address zero.
// - user-flash mapping applies no overlay; vectors come from flash bottom.
// - user-RAM mapping serves the low window from the bottom of SRAM.
// - the overlay covers 64 bytes, addresses 0x00 through 0x3F.
// - remapped memory stays reachable at its own original addresses too.
// - outside the overlay every region keeps one fixed range in all modes.
// - the whole boot block decodes at the top of on-chip memory space.
// - accesses from end of fitted flash up to below SRAM abort.
// - accesses from end of fitted SRAM up to below boot block abort.
// - the reserved middle range 0x80000000 to 0xDFFFFFFF always aborts.
// - reserved peripheral space and unpopulated peripheral slots abort.
// - illegal data access gives data abort; illegal fetch gives prefetch abort.
// - any instruction fetch from peripheral space gives a prefetch abort.
// - data access to undefined offset in a populated slot does not abort.
// - peripherals decode only needed bits; aliasing inside a slot is allowed.
// - each peripheral region is 128 slots of 16 kB chosen by upper bits.
// - APB slot 127 selects the system control block; AHB slot 127 does not.
`timescale 1ns/1ps
`default_nettype none

module vrad_decoder #(
  parameter int FLASH_KB = vrad_pkg::FLASH_KB_DEF,
  parameter int SRAM_KB = vrad_pkg::SRAM_KB_DEF,
  parameter logic [127:0] APB_SLOTS = vrad_pkg::APB_SLOTS_DEF,
  parameter logic [127:0] AHB_SLOTS = vrad_pkg::AHB_SLOTS_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // mapping-mode control from system control logic
  input wire logic map_wr_en,
  input wire logic [1:0] map_wr_mode,
  output logic [1:0] map_mode_ff,
  // request from the core bus
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_fetch,
  // response, one cycle after the request
  output logic rsp_valid_ff,
  output logic rsp_fetch_ff,
  // abort report for the same response
  output logic rsp_abort_data_ff,
  output logic rsp_abort_fetch_ff,
  output logic [2:0] rsp_cause_ff,
  // where the access fell
  output logic rsp_overlay_ff,
  output logic rsp_vector_ff,
  // target selection for the same response
  output logic sel_flash_ff,
  output logic sel_sram_ff,
  output logic sel_boot_ff,
  output logic sel_apb_ff,
  output logic sel_ahb_ff,
  output logic sel_syscon_ff,
  // translated address
  output logic [6:0] sel_slot_ff,
  output logic [31:0] tgt_addr_ff
);

  // mode control state

  vrad_pkg::vrad_map_t mode_q_ff;
  vrad_pkg::vrad_map_t nxt_mode;

  // the unused code 11 is ignored, so the mode never leaves the three defined ones
  always_comb begin
    nxt_mode = mode_q_ff;
    if (map_wr_en) begin
      unique case (map_wr_mode)
        2'h0: nxt_mode = vrad_pkg::MAP_BOOT;
        2'h1: nxt_mode = vrad_pkg::MAP_FLASH;
        2'h2: nxt_mode = vrad_pkg::MAP_RAM;
        2'h3: nxt_mode = mode_q_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q_ff <= vrad_pkg::MAP_RESET;
    end else begin
      mode_q_ff <= nxt_mode;
    end
  end

  assign map_mode_ff = mode_q_ff;

  // fixed-region classification of the raw address

  vrad_pkg::vrad_region_t raw_region;
  vrad_pkg::vrad_cause_t raw_cause;
  logic [6:0] raw_slot;

  vrad_region #(
    .FLASH_KB(FLASH_KB),
    .SRAM_KB(SRAM_KB),
    .APB_SLOTS(APB_SLOTS),
    .AHB_SLOTS(AHB_SLOTS)
  ) u_region (
    .addr(req_addr),
    .region(raw_region),
    .cause(raw_cause),
    .slot(raw_slot)
  );

  // overlay and abort decision

  // the window and the vector words are both ranges that start at address zero
  function automatic logic at_or_below(input logic [31:0] a, input logic [31:0] lim);
    at_or_below = (a <= lim);
  endfunction : at_or_below

  logic in_window;
  logic in_vectors;
  logic [31:0] win_offset;
  vrad_pkg::vrad_region_t eff_region;
  vrad_pkg::vrad_cause_t eff_cause;
  logic [31:0] eff_addr;
  logic overlay_hit;
  logic is_peri;
  logic fault;

  // the window is the low 64 bytes; only the overlay looks at it, the rest is fixed
  assign in_window = at_or_below(req_addr, vrad_pkg::OVL_LAST);
  assign in_vectors = at_or_below(req_addr, vrad_pkg::VEC_LAST);
  assign win_offset = {26'h000_0000, req_addr[vrad_pkg::OVL_BITS-1:0]};

  always_comb begin
    eff_region = raw_region;
    eff_addr = req_addr;
    overlay_hit = 1'b0;
    if (in_window) begin
      unique case (mode_q_ff)
        vrad_pkg::MAP_BOOT: begin
          eff_region = vrad_pkg::RG_BOOT;
          eff_addr = vrad_pkg::BOOT_BASE | win_offset;
          overlay_hit = 1'b1;
        end
        vrad_pkg::MAP_FLASH: begin
          eff_region = vrad_pkg::RG_FLASH;
          eff_addr = vrad_pkg::FLASH_BASE | win_offset;
        end
        vrad_pkg::MAP_RAM: begin
          eff_region = vrad_pkg::RG_SRAM;
          eff_addr = vrad_pkg::SRAM_BASE | win_offset;
          overlay_hit = 1'b1;
        end
      endcase
    end
  end

  assign is_peri = (eff_region == vrad_pkg::RG_APB) || (eff_region == vrad_pkg::RG_AHB) ||
                   (raw_cause == vrad_pkg::CS_NO_SLOT);
  assign fault = (raw_cause != vrad_pkg::CS_NONE) && !in_window;

  always_comb begin
    eff_cause = in_window ? vrad_pkg::CS_NONE : raw_cause;
    // a fetch from peripheral space is refused even from a populated slot
    if (req_fetch && is_peri && !fault) begin
      eff_cause = vrad_pkg::CS_FETCH_PERI;
    end
  end

  // abort decision shared by the response status and target select groups below

  logic refuse;

  assign refuse = req_valid && (eff_cause != vrad_pkg::CS_NONE);

  // response status registers

  logic nxt_valid;
  logic nxt_fetch;
  logic nxt_abort_data;
  logic nxt_abort_fetch;
  logic [2:0] nxt_cause;
  logic nxt_overlay;
  logic nxt_vector;

  always_comb begin
    nxt_valid = req_valid;
    nxt_fetch = 1'b0;
    nxt_abort_data = 1'b0;
    nxt_abort_fetch = 1'b0;
    nxt_cause = vrad_pkg::CS_NONE;
    nxt_overlay = 1'b0;
    nxt_vector = 1'b0;
    if (req_valid) begin
      nxt_fetch = req_fetch;
      nxt_cause = eff_cause;
      nxt_overlay = overlay_hit;
      nxt_vector = in_vectors;
    end
    if (refuse) begin
      // the core holds this flag with the word and only traps if it executes
      nxt_abort_fetch = req_fetch;
      nxt_abort_data = !req_fetch;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_fetch_ff <= 1'b0;
      rsp_abort_data_ff <= 1'b0;
      rsp_abort_fetch_ff <= 1'b0;
      rsp_cause_ff <= vrad_pkg::CS_NONE;
      rsp_overlay_ff <= 1'b0;
      rsp_vector_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= nxt_valid;
      rsp_fetch_ff <= nxt_fetch;
      rsp_abort_data_ff <= nxt_abort_data;
      rsp_abort_fetch_ff <= nxt_abort_fetch;
      rsp_cause_ff <= nxt_cause;
      rsp_overlay_ff <= nxt_overlay;
      rsp_vector_ff <= nxt_vector;
    end
  end

  // target select registers

  // one-hot region codes double as select vectors, so each select is one code bit
  localparam int SEL_FLASH = $clog2(vrad_pkg::RG_FLASH);
  localparam int SEL_SRAM = $clog2(vrad_pkg::RG_SRAM);
  localparam int SEL_BOOT = $clog2(vrad_pkg::RG_BOOT);
  localparam int SEL_APB = $clog2(vrad_pkg::RG_APB);
  localparam int SEL_AHB = $clog2(vrad_pkg::RG_AHB);

  logic [5:0] nxt_sel;
  logic nxt_syscon;
  logic [5:0] sel_q_ff;
  logic syscon_q_ff;

  always_comb begin
    nxt_sel = 6'h00;
    nxt_syscon = 1'b0;
    if (req_valid && !refuse) begin
      nxt_sel = eff_region;
      nxt_syscon = (eff_region == vrad_pkg::RG_APB) &&
                   (raw_slot == vrad_pkg::SYSCON_SLOT);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q_ff <= 6'h00;
      syscon_q_ff <= 1'b0;
    end else begin
      sel_q_ff <= nxt_sel;
      syscon_q_ff <= nxt_syscon;
    end
  end

  // selects are single bits of the one-hot region flop, so they stay flop outputs
  assign sel_flash_ff = sel_q_ff[SEL_FLASH];
  assign sel_sram_ff = sel_q_ff[SEL_SRAM];
  assign sel_boot_ff = sel_q_ff[SEL_BOOT];
  assign sel_apb_ff = sel_q_ff[SEL_APB];
  assign sel_ahb_ff = sel_q_ff[SEL_AHB];
  assign sel_syscon_ff = syscon_q_ff;

  // target address registers

  // the slot follows the raw address everywhere; it only means something on a peripheral hit
  logic [6:0] nxt_slot;
  logic [31:0] nxt_tgt;

  always_comb begin
    nxt_slot = 7'h00;
    nxt_tgt = 32'h0000_0000;
    if (req_valid) begin
      nxt_slot = raw_slot;
      nxt_tgt = eff_addr;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_slot_ff <= 7'h00;
      tgt_addr_ff <= 32'h0000_0000;
    end else begin
      sel_slot_ff <= nxt_slot;
      tgt_addr_ff <= nxt_tgt;
    end
  end

endmodule : vrad_decoder

`default_nettype wire

// [rtl/vrad_pkg.sv]
// vrad_pkg: address map, mapping-mode codes and abort causes for the vector remap decoder
// assumes a flat 32-bit byte address space seen by one processor bus master
package vrad_pkg;

  // exception vectors and the low overlay window
  localparam logic [31:0] VEC_FIRST = 32'h0000_0000;
  localparam logic [31:0] VEC_LAST = 32'h0000_001C;
  localparam logic [31:0] OVL_LAST = 32'h0000_003F;
  localparam int OVL_BITS = 6;

  // fixed memory regions
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
  localparam logic [31:0] SRAM_GAP_LAST = 32'h7FFF_CFFF;
  localparam logic [31:0] BOOT_BASE = 32'h7FFF_D000;
  localparam logic [31:0] BOOT_LAST = 32'h7FFF_FFFF;
  localparam logic [31:0] RSV_MID_FIRST = 32'h8000_0000;
  localparam logic [31:0] RSV_MID_LAST = 32'hDFFF_FFFF;

  // peripheral bus regions: 2 MB each, 128 slots of 16 kB
  localparam logic [31:0] APB_BASE = 32'hE000_0000;
  localparam logic [31:0] APB_LAST = 32'hE01F_FFFF;
  localparam logic [31:0] AHB_BASE = 32'hFFE0_0000;
  localparam logic [31:0] AHB_LAST = 32'hFFFF_FFFF;
  localparam int SLOT_LSB = 14;
  localparam int SLOT_W = 7;
  localparam int SLOT_COUNT = 128;
  localparam logic [6:0] SYSCON_SLOT = 7'h7F;

  // default population of slots, bit n set when slot n holds a peripheral
  localparam logic [127:0] APB_SLOTS_DEF =
    128'h8000_0000_0000_0000_0000_0000_0D80_2FBF;
  localparam logic [127:0] AHB_SLOTS_DEF =
    128'h8000_0000_0000_0000_0000_0000_0000_0000;

  localparam int FLASH_KB_DEF = 512;
  localparam int SRAM_KB_DEF = 32;

  // mapping modes as held in the control register
  typedef enum logic [1:0] {
    MAP_BOOT = 2'h0,
    MAP_FLASH = 2'h1,
    MAP_RAM = 2'h2
  } vrad_map_t;
  localparam vrad_map_t MAP_RESET = MAP_BOOT;

  // decoded target, one-hot
  typedef enum logic [5:0] {
    RG_NONE = 6'h01,
    RG_FLASH = 6'h02,
    RG_SRAM = 6'h04,
    RG_BOOT = 6'h08,
    RG_APB = 6'h10,
    RG_AHB = 6'h20
  } vrad_region_t;

  // why an access was refused
  typedef enum logic [2:0] {
    CS_NONE = 3'h0,
    CS_FLASH_GAP = 3'h1,
    CS_SRAM_GAP = 3'h2,
    CS_RSV_MID = 3'h3,
    CS_RSV_PERI = 3'h4,
    CS_NO_SLOT = 3'h5,
    CS_FETCH_PERI = 3'h6
  } vrad_cause_t;

endpackage : vrad_pkg

// [rtl/vrad_region.sv]
// vrad_region: combinational classification of a raw bus address into its fixed region
// assumes the caller applies the low vector overlay and registers the result
`timescale 1ns/1ps
`default_nettype none

module vrad_region #(
  parameter int FLASH_KB = vrad_pkg::FLASH_KB_DEF,
  parameter int SRAM_KB = vrad_pkg::SRAM_KB_DEF,
  parameter logic [127:0] APB_SLOTS = vrad_pkg::APB_SLOTS_DEF,
  parameter logic [127:0] AHB_SLOTS = vrad_pkg::AHB_SLOTS_DEF
) (
  // address under test
  input wire logic [31:0] addr,
  // classification
  output vrad_pkg::vrad_region_t region,
  output vrad_pkg::vrad_cause_t cause,
  output logic [6:0] slot
);

  localparam logic [31:0] FLASH_END = 32'(FLASH_KB * 1024);
  localparam logic [31:0] SRAM_END = vrad_pkg::SRAM_BASE + 32'(SRAM_KB * 1024);

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  logic in_apb;
  logic in_ahb;
  logic present;

  assign slot = addr[vrad_pkg::SLOT_LSB +: vrad_pkg::SLOT_W];
  assign in_apb = in_range(addr, vrad_pkg::APB_BASE, vrad_pkg::APB_LAST);
  assign in_ahb = in_range(addr, vrad_pkg::AHB_BASE, vrad_pkg::AHB_LAST);
  // peripherals decode only what they need inside a slot, so any offset there is fine
  assign present = in_apb ? APB_SLOTS[slot] : AHB_SLOTS[slot];

  always_comb begin
    region = vrad_pkg::RG_NONE;
    cause = vrad_pkg::CS_NONE;
    if (addr < FLASH_END) begin
      region = vrad_pkg::RG_FLASH;
    end else if (addr < vrad_pkg::SRAM_BASE) begin
      cause = vrad_pkg::CS_FLASH_GAP;
    end else if (addr < SRAM_END) begin
      region = vrad_pkg::RG_SRAM;
    end else if (in_range(addr, SRAM_END, vrad_pkg::SRAM_GAP_LAST)) begin
      cause = vrad_pkg::CS_SRAM_GAP;
    end else if (in_range(addr, vrad_pkg::BOOT_BASE, vrad_pkg::BOOT_LAST)) begin
      region = vrad_pkg::RG_BOOT;
    end else if (in_range(addr, vrad_pkg::RSV_MID_FIRST, vrad_pkg::RSV_MID_LAST)) begin
      cause = vrad_pkg::CS_RSV_MID;
    end else if (in_apb || in_ahb) begin
      if (present) begin
        region = in_apb ? vrad_pkg::RG_APB : vrad_pkg::RG_AHB;
      end else begin
        cause = vrad_pkg::CS_NO_SLOT;
      end
    end else begin
      cause = vrad_pkg::CS_RSV_PERI;
    end
  end

endmodule : vrad_region

`default_nettype wire

// [tb/vrad_core_bfm.sv]
// vrad_core_bfm: processor bus master issuing one access at a time
// assumes the decoder answers one cycle after the request edge
`timescale 1ns/1ps
`default_nettype none

module vrad_core_bfm (
  // clock
  input wire logic sys_clk,
  // request to the decoder
  output logic req_valid,
  output logic [31:0] req_addr,
  output logic req_fetch,
  // prefetch abort travelling with the fetched word
  input wire logic abort_in,
  output logic pf_flag
);
  initial begin
    req_valid = 1'b0;
    req_addr = 32'h0000_0000;
    req_fetch = 1'b0;
    pf_flag = 1'b0;
  end

  // released lines show flipped bits so a stale address is never trusted
  task automatic issue(input logic [31:0] a, input logic f);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_addr = a;
    req_fetch = f;
    @(posedge sys_clk);
    #1;
    pf_flag = f & abort_in;
    req_valid = 1'b0;
    req_addr = ~a;
    req_fetch = ~f;
  endtask : issue
endmodule : vrad_core_bfm
`default_nettype wire

// [tb/vrad_chk.sv]
// vrad_chk: timing and mapping checks on the decoder ports
// assumes one clock domain and the response one cycle after the request
`timescale 1ns/1ps
`default_nettype none

module vrad_chk (
  // clock, reset, mode control
  input wire logic sys_clk, arst_n, map_wr_en,
  input wire logic [1:0] map_wr_mode, map_mode_ff,
  // request and translated address
  input wire logic req_valid, req_fetch,
  input wire logic [31:0] req_addr, tgt_addr_ff,
  // response
  input wire logic rsp_valid_ff, rsp_abort_data_ff, rsp_abort_fetch_ff, rsp_overlay_ff,
  input wire logic sel_flash_ff, sel_sram_ff, sel_boot_ff, sel_apb_ff, sel_ahb_ff,
  input wire logic sel_syscon_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic any_sel, low, apb;
  assign any_sel = sel_flash_ff | sel_sram_ff | sel_boot_ff | sel_apb_ff | sel_ahb_ff;
  assign low = req_valid && req_addr <= 32'h0000_003F;
  assign apb = req_addr[31:21] == 11'h700;

  property p_rsp_lat;
    1 |=> rsp_valid_ff == $past(req_valid);
  endproperty
  a_rsp_lat: assert property (p_rsp_lat) else $error("response not one cycle later");
  property p_boot_ovl;
    low && map_mode_ff == 2'h0 |=> sel_boot_ff && rsp_overlay_ff
      && tgt_addr_ff == {26'h1FF_FF40, $past(req_addr[5:0])};
  endproperty
  a_boot_ovl: assert property (p_boot_ovl) else $error("boot overlay wrong");
  property p_ram_ovl;
    low && map_mode_ff == 2'h2 |=> sel_sram_ff && rsp_overlay_ff
      && tgt_addr_ff == {26'h100_0000, $past(req_addr[5:0])};
  endproperty
  a_ram_ovl: assert property (p_ram_ovl) else $error("ram overlay wrong");
  property p_flash_low;
    low && map_mode_ff == 2'h1 |=> sel_flash_ff && !rsp_overlay_ff
      && tgt_addr_ff == $past(req_addr);
  endproperty
  a_flash_low: assert property (p_flash_low) else $error("flash mode redirected");
  property p_win_edge;
    req_valid && req_addr == 32'h0000_0040 |=> sel_flash_ff && !rsp_overlay_ff;
  endproperty
  a_win_edge: assert property (p_win_edge) else $error("overlay past 64 bytes");
  property p_mid;
    req_valid && req_addr >= 32'h8000_0000 && req_addr <= 32'hDFFF_FFFF |=> !any_sel
      && rsp_abort_fetch_ff == $past(req_fetch) && rsp_abort_data_ff != $past(req_fetch);
  endproperty
  a_mid: assert property (p_mid) else $error("middle range not aborted");
  property p_fetch_apb;
    req_valid && req_fetch && apb |=> rsp_abort_fetch_ff && !rsp_abort_data_ff && !any_sel;
  endproperty
  a_fetch_apb: assert property (p_fetch_apb) else $error("peripheral fetch passed");
  property p_abort_nosel;
    rsp_abort_data_ff || rsp_abort_fetch_ff |-> rsp_valid_ff && !any_sel;
  endproperty
  a_abort_nosel: assert property (p_abort_nosel) else $error("aborted access selected");
  property p_mode_wr;
    map_wr_en |=> map_mode_ff == ($past(map_wr_mode) == 2'h3 ? $past(map_mode_ff)
      : $past(map_wr_mode));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write wrong");
  property p_syscon;
    req_valid && !req_fetch && req_addr[31:14] == 18'h3_807F |=> sel_syscon_ff && sel_apb_ff;
  endproperty
  a_syscon: assert property (p_syscon) else $error("system control slot missed");
endmodule : vrad_chk

bind vrad_decoder vrad_chk u_chk (.sys_clk, .arst_n, .map_wr_en, .map_wr_mode, .map_mode_ff,
  .req_valid, .req_fetch, .req_addr, .tgt_addr_ff, .rsp_valid_ff, .rsp_abort_data_ff,
  .rsp_abort_fetch_ff, .rsp_overlay_ff, .sel_flash_ff, .sel_sram_ff, .sel_boot_ff,
  .sel_apb_ff, .sel_ahb_ff, .sel_syscon_ff);
`default_nettype wire

// [tb/tb_top.sv]
// tb_top: directed scenarios for the vector remap decoder
// assumes default flash, sram and slot population parameters
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic sys_clk, arst_n, map_wr_en, req_valid, req_fetch, ad, af, ovl, vec, pf, syscon, vld, fch;
  logic [1:0] map_wr_mode, mode;
  logic [1:0] cur_mode = 2'h0;
  logic [6:0] slot;
  logic [2:0] cause;
  logic [4:0] sel;
  logic [31:0] req_addr, tgt;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  vrad_decoder DUT (.sys_clk(sys_clk), .arst_n(arst_n), .map_wr_en(map_wr_en),
    .map_wr_mode(map_wr_mode), .map_mode_ff(mode), .req_valid(req_valid),
    .req_addr(req_addr), .req_fetch(req_fetch), .rsp_valid_ff(vld), .rsp_fetch_ff(fch),
    .rsp_abort_data_ff(ad), .rsp_abort_fetch_ff(af), .rsp_cause_ff(cause),
    .rsp_overlay_ff(ovl), .rsp_vector_ff(vec), .sel_flash_ff(sel[0]), .sel_sram_ff(sel[1]),
    .sel_boot_ff(sel[2]), .sel_apb_ff(sel[3]), .sel_ahb_ff(sel[4]),
    .sel_syscon_ff(syscon), .sel_slot_ff(slot), .tgt_addr_ff(tgt));
  vrad_core_bfm core (.sys_clk(sys_clk), .req_valid(req_valid), .req_addr(req_addr),
    .req_fetch(req_fetch), .abort_in(af), .pf_flag(pf));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // s: {ahb,apb,boot,sram,flash}, ab: {fetch abort, data abort}
  task automatic acc(input logic [31:0] a, input logic f, input logic [4:0] s,
    input logic [1:0] ab, input logic [2:0] c, input logic [31:0] t);
    logic ovl_exp;
    logic vec_exp;
    ovl_exp = (a <= 32'h0000_003F) && (cur_mode != 2'h1);
    vec_exp = (a <= 32'h0000_001C);
    core.issue(a, f);
    chk(32'({vld, fch, ovl, vec, sel, af, ad, cause}),
      32'({1'b1, f, ovl_exp, vec_exp, s, ab, c}));
    chk(32'(slot), 32'(a[20:14]));
    if (s != 5'h00) chk(tgt, t);
  endtask : acc

  task automatic set_mode(input logic [1:0] m);
    @(posedge sys_clk);
    #1;
    map_wr_en = 1'b1;
    map_wr_mode = m;
    if (m != 2'h3) cur_mode = m;
    @(posedge sys_clk);
    #1;
    map_wr_en = 1'b0;
  endtask : set_mode

  task automatic t_boot();
    chk(32'(mode), 32'h0000_0000);
    acc(32'h0000_0010, 1'b0, 5'h04, 2'h0, 3'h0, 32'h7FFF_D010);
    acc(32'h0000_003F, 1'b1, 5'h04, 2'h0, 3'h0, 32'h7FFF_D03F);
    acc(32'h0000_0040, 1'b0, 5'h01, 2'h0, 3'h0, 32'h0000_0040);
    acc(32'h7FFF_D000, 1'b1, 5'h04, 2'h0, 3'h0, 32'h7FFF_D000);
    $display("t_boot done");
  endtask : t_boot

  task automatic t_flash();
    set_mode(2'h1);
    acc(32'h0000_001C, 1'b1, 5'h01, 2'h0, 3'h0, 32'h0000_001C);
    chk(32'(vec), 32'h0000_0001);
    set_mode(2'h3);
    chk(32'(mode), 32'h0000_0001);
    $display("t_flash done");
  endtask : t_flash

  task automatic t_ram();
    set_mode(2'h2);
    acc(32'h0000_0000, 1'b0, 5'h02, 2'h0, 3'h0, 32'h4000_0000);
    acc(32'h4000_0000, 1'b0, 5'h02, 2'h0, 3'h0, 32'h4000_0000);
    acc(32'h0000_0044, 1'b1, 5'h01, 2'h0, 3'h0, 32'h0000_0044);
    $display("t_ram done");
  endtask : t_ram

  task automatic t_gaps();
    acc(32'h0008_0000, 1'b0, 5'h00, 2'h1, 3'h1, 32'h0);
    acc(32'h3FFF_FFFC, 1'b1, 5'h00, 2'h2, 3'h1, 32'h0);
    acc(32'h4000_8000, 1'b0, 5'h00, 2'h1, 3'h2, 32'h0);
    acc(32'h7FFF_CFFF, 1'b1, 5'h00, 2'h2, 3'h2, 32'h0);
    acc(32'h8000_0000, 1'b0, 5'h00, 2'h1, 3'h3, 32'h0);
    acc(32'hDFFF_FFFF, 1'b1, 5'h00, 2'h2, 3'h3, 32'h0);
    $display("t_gaps done");
  endtask : t_gaps

  task automatic t_peri();
    acc(32'hE000_D000, 1'b0, 5'h08, 2'h0, 3'h0, 32'hE000_D000);
    acc(32'hE000_C000, 1'b1, 5'h00, 2'h2, 3'h6, 32'h0);
    chk(32'(pf), 32'h0000_0001);
    acc(32'hE001_8000, 1'b0, 5'h00, 2'h1, 3'h5, 32'h0);
    acc(32'hE020_0000, 1'b0, 5'h00, 2'h1, 3'h4, 32'h0);
    acc(32'hFFE0_4000, 1'b0, 5'h00, 2'h1, 3'h5, 32'h0);
    acc(32'hFFFF_C000, 1'b0, 5'h10, 2'h0, 3'h0, 32'hFFFF_C000);
    acc(32'hE01F_C000, 1'b0, 5'h08, 2'h0, 3'h0, 32'hE01F_C000);
    chk(32'(syscon), 32'h0000_0001);
    $display("t_peri done");
  endtask : t_peri

  task automatic t_rerst();
    @(posedge sys_clk);
    #1;
    arst_n = 1'b0;
    cur_mode = 2'h0;
    #1;
    chk(32'(mode), 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    acc(32'h0000_0000, 1'b0, 5'h04, 2'h0, 3'h0, 32'h7FFF_D000);
    $display("t_rerst done");
  endtask : t_rerst

  // the whole run needs under a hundred cycles; this only catches a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    arst_n = 1'b0;
    map_wr_en = 1'b0;
    map_wr_mode = 2'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    t_boot();
    t_flash();
    t_ram();
    t_gaps();
    t_peri();
    set_mode(2'h2);
    t_rerst();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
